// ===== core/ocsd_sequencer.sv
// Order code sequence decoder: steps each instruction through its subinstructions
`timescale 1ns/1ps
`include "ocsd_map.svh"

// Notes on behaviour
// - Code 00 is branch_op: one branch_step, one memory cycle.
// - Code 03 is swap_op: swap_step then next_fetch_step, two cycles.
// - Code 14 is negate load: negate_load_step then next_fetch_step, two cycles.
// - Codes 15 store and 17 and: own step then next_fetch_step, two cycles.
// - Code 16 is sum_op: sum_step then next_fetch_step, two cycles normally.
// - Sum overflow appends counter_up, underflow counter_down; three cycles then.
// - Code 02 is index_next: index_step_a then index_step_b, two cycles.
// - Code 01 compare skip: compare_skip_step_a then _b, two cycles.
// - Extra 13 difference: four cycles, five with appended counter cycle.
// - Extra 11 product takes ten cycles; extra 12 quotient takes eighteen.
// - Involuntary counter_up: one cycle, no order code loaded.
// - Involuntary counter_down: one cycle.
// - Counter_shift and counter_shift_plus_one: one cycle each.
// - Machine_kickoff and start_at_address: one cycle each.
// - Display_location presents a location: one cycle.
// - Load_location writes a location: one cycle.
// - Every subinstruction is one memory cycle of twelve actions.
// - Product: first step three times, middle step six times, last once.
module ocsd_sequencer #(
	parameter int PROD_REPEAT = `OCSD_PROD_REPEAT,
	parameter int QUOT_REPEAT = `OCSD_QUOT_REPEAT,
	parameter int EXTRA_OVH = `OCSD_EXTRA_OVH
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic order_valid,
	input wire logic [3:0] order_code,
	input wire logic extra_code,
	output logic order_ready,
	input wire logic [7:0] inv_req,
	output logic [7:0] inv_ack,
	input wire logic sum_overflow,
	input wire logic sum_underflow,
	output ocsd_pkg::ocsd_step_t step,
	output logic [3:0] action,
	output logic action_end,
	output logic [4:0] mct_index,
	output logic seq_done,
	output logic undefined_code
);
	ocsd_pkg::ocsd_step_t step_q;
	ocsd_pkg::ocsd_step_t step_d;
	ocsd_pkg::ocsd_pend_t pend_q;
	ocsd_pkg::ocsd_pend_t pend_d;
	logic [4:0] rep_q;
	logic [4:0] rep_d;
	logic [4:0] mct_q;
	logic [4:0] mct_d;
	logic undef_q;
	logic undef_d;
	logic busy;
	logic mct_end;
	logic last_rep;
	logic final_mct;
	logic boundary;
	logic inv_any;
	logic [7:0] grant;
	ocsd_pkg::ocsd_step_t dec_step;
	logic [4:0] dec_rep;
	logic dec_undef;
	ocsd_pkg::ocsd_step_t inv_step;

	// Step for a granted involuntary slot
	function automatic ocsd_pkg::ocsd_step_t inv_to_step(input logic [7:0] g);
		ocsd_pkg::ocsd_step_t s;
		s = ocsd_pkg::S_IDLE;
		if (g[`OCSD_INV_KICKOFF]) begin
			s = ocsd_pkg::S_KICKOFF;
		end else if (g[`OCSD_INV_START_AT]) begin
			s = ocsd_pkg::S_START_AT;
		end else if (g[`OCSD_INV_CNT_UP]) begin
			s = ocsd_pkg::S_CNT_UP;
		end else if (g[`OCSD_INV_CNT_DOWN]) begin
			s = ocsd_pkg::S_CNT_DOWN;
		end else if (g[`OCSD_INV_CNT_SHIFT]) begin
			s = ocsd_pkg::S_CNT_SHIFT;
		end else if (g[`OCSD_INV_CNT_SHIFT_P1]) begin
			s = ocsd_pkg::S_CNT_SHIFT_P1;
		end else if (g[`OCSD_INV_DISPLAY]) begin
			s = ocsd_pkg::S_DISPLAY;
		end else if (g[`OCSD_INV_LOAD]) begin
			s = ocsd_pkg::S_LOAD;
		end
		return s;
	endfunction

	// True for a step after which the instruction ends
	function automatic logic is_terminal(input ocsd_pkg::ocsd_step_t s,
			input ocsd_pkg::ocsd_pend_t p);
		logic t;
		t = 1'b0;
		case (s)
			ocsd_pkg::S_BRANCH,
			ocsd_pkg::S_INDEX_B,
			ocsd_pkg::S_CMP_B,
			ocsd_pkg::S_PROD_LAST,
			ocsd_pkg::S_CNT_UP,
			ocsd_pkg::S_CNT_DOWN,
			ocsd_pkg::S_CNT_SHIFT,
			ocsd_pkg::S_CNT_SHIFT_P1,
			ocsd_pkg::S_KICKOFF,
			ocsd_pkg::S_START_AT,
			ocsd_pkg::S_DISPLAY,
			ocsd_pkg::S_LOAD: t = 1'b1;
			ocsd_pkg::S_NEXT_FETCH: t = (p == ocsd_pkg::P_NONE);
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	// Twelve actions to each memory cycle
	ocsd_action_timer #(
		.ACTIONS(`OCSD_ACT_COUNT)
	) u_timer (
		.ref_clk(ref_clk),
		.reset(reset),
		.run(busy),
		.action(action),
		.mct_end(mct_end)
	);

	// Order code decode
	ocsd_decode #(
		.EXTRA_OVH(EXTRA_OVH)
	) u_decode (
		.order_code(order_code),
		.extra_code(extra_code),
		.first_step(dec_step),
		.first_rep(dec_rep),
		.undefined(dec_undef)
	);

	// Fixed priority among involuntary requests
	genvar gi;
	generate
		for (gi = 0; gi < `OCSD_INV_N; gi++) begin : g_grant
			if (gi == 0) begin : g_top
				assign grant[gi] = inv_req[gi];
			end else begin : g_rest
				assign grant[gi] = inv_req[gi] && !(|inv_req[gi-1:0]);
			end
		end
	endgenerate

	// Instruction boundary and handshake terms
	assign busy = (step_q != ocsd_pkg::S_IDLE);
	assign last_rep = (rep_q == `OCSD_REP_ONE);
	assign final_mct = busy && last_rep && is_terminal(step_q, pend_q);
	assign boundary = !busy || (mct_end && final_mct);
	assign inv_any = |inv_req;
	assign inv_step = inv_to_step(grant);
	assign inv_ack = boundary ? grant : 8'h00;
	assign order_ready = boundary && !inv_any;

	// Status outputs
	assign step = step_q;
	assign action_end = mct_end;
	assign mct_index = mct_q;
	assign seq_done = final_mct;
	assign undefined_code = undef_q;

	// Next subinstruction, repeat count and appended counter cycle
	always_comb begin
		step_d = step_q;
		rep_d = rep_q;
		pend_d = pend_q;
		mct_d = mct_q;
		undef_d = 1'b0;
		if (boundary) begin
			// Take the next instruction, involuntary first
			step_d = ocsd_pkg::S_IDLE;
			rep_d = `OCSD_REP_ONE;
			pend_d = ocsd_pkg::P_NONE;
			mct_d = `OCSD_MCT_FIRST;
			if (inv_any) begin
				step_d = inv_step;
			end else if (order_valid) begin
				if (dec_undef) begin
					undef_d = 1'b1;
				end else begin
					step_d = dec_step;
					rep_d = dec_rep;
				end
			end
		end else if (mct_end) begin
			mct_d = mct_q + 5'h01;
			if (!last_rep) begin
				rep_d = rep_q - 5'h01;
			end else begin
				rep_d = `OCSD_REP_ONE;
				case (step_q)
					ocsd_pkg::S_SWAP,
					ocsd_pkg::S_NEG_LOAD,
					ocsd_pkg::S_STORE,
					ocsd_pkg::S_AND,
					ocsd_pkg::S_QUOT_B: begin
						step_d = ocsd_pkg::S_NEXT_FETCH;
					end
					ocsd_pkg::S_SUM,
					ocsd_pkg::S_DIFF: begin
						// Capture carry out of the add or subtract
						step_d = ocsd_pkg::S_NEXT_FETCH;
						if (sum_overflow) begin
							pend_d = ocsd_pkg::P_UP;
						end else if (sum_underflow) begin
							pend_d = ocsd_pkg::P_DOWN;
						end else begin
							pend_d = ocsd_pkg::P_NONE;
						end
					end
					ocsd_pkg::S_INDEX_A: begin
						step_d = ocsd_pkg::S_INDEX_B;
					end
					ocsd_pkg::S_CMP_A: begin
						step_d = ocsd_pkg::S_CMP_B;
					end
					ocsd_pkg::S_PROD_FIRST: begin
						step_d = ocsd_pkg::S_PROD_REPEAT;
						rep_d = 5'(PROD_REPEAT);
					end
					ocsd_pkg::S_PROD_REPEAT: begin
						step_d = ocsd_pkg::S_PROD_LAST;
					end
					ocsd_pkg::S_QUOT_A: begin
						step_d = ocsd_pkg::S_QUOT_B;
						rep_d = 5'(QUOT_REPEAT);
					end
					ocsd_pkg::S_NEXT_FETCH: begin
						// Appended counter cycle after the fetch
						if (pend_q == ocsd_pkg::P_UP) begin
							step_d = ocsd_pkg::S_CNT_UP;
						end else begin
							step_d = ocsd_pkg::S_CNT_DOWN;
						end
						pend_d = ocsd_pkg::P_NONE;
					end
					default: begin
						step_d = ocsd_pkg::S_IDLE;
					end
				endcase
			end
		end
	end

	// Register sequencing state
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			step_q <= ocsd_pkg::S_IDLE;
			rep_q <= `OCSD_REP_ONE;
			pend_q <= ocsd_pkg::P_NONE;
			mct_q <= `OCSD_MCT_FIRST;
			undef_q <= 1'b0;
		end else begin
			step_q <= step_d;
			rep_q <= rep_d;
			pend_q <= pend_d;
			mct_q <= mct_d;
			undef_q <= undef_d;
		end
	end
endmodule

// ===== core/ocsd_map.svh
// Constants for the order code sequence decoder: codes, counts and action numbers
`ifndef OCSD_MAP_SVH
`define OCSD_MAP_SVH

// Order codes held in the order code register (octal figures in hex form)
`define OCSD_OC_BRANCH 4'h0
`define OCSD_OC_COMPARE_SKIP 4'h1
`define OCSD_OC_INDEX 4'h2
`define OCSD_OC_SWAP 4'h3
`define OCSD_OC_NEG_LOAD 4'hC
`define OCSD_OC_STORE 4'hD
`define OCSD_OC_SUM 4'hE
`define OCSD_OC_AND 4'hF

// Extra-code order codes
`define OCSD_XC_PRODUCT 4'h9
`define OCSD_XC_QUOTIENT 4'hA
`define OCSD_XC_DIFFERENCE 4'hB

// Actions within one memory cycle, pulses 01 through 12
`define OCSD_ACT_FIRST 4'h1
`define OCSD_ACT_LAST 4'hC
`define OCSD_ACT_COUNT 12

// Memory cycle counts
`define OCSD_REP_W 5
`define OCSD_REP_ONE 5'h01
`define OCSD_MCT_FIRST 5'h01
`define OCSD_EXTRA_OVH 2
`define OCSD_PROD_REPEAT 6
`define OCSD_QUOT_REPEAT 14

// Involuntary request slots, lowest index has priority
`define OCSD_INV_N 8
`define OCSD_INV_KICKOFF 0
`define OCSD_INV_START_AT 1
`define OCSD_INV_CNT_UP 2
`define OCSD_INV_CNT_DOWN 3
`define OCSD_INV_CNT_SHIFT 4
`define OCSD_INV_CNT_SHIFT_P1 5
`define OCSD_INV_DISPLAY 6
`define OCSD_INV_LOAD 7

`endif

// ===== core/ocsd_pkg.sv
// Types shared by the order code sequence decoder
package ocsd_pkg;

	// Subinstruction being executed, one-hot
	typedef enum logic [25:0] {
		S_IDLE = 26'h000_0001,
		S_BRANCH = 26'h000_0002,
		S_SWAP = 26'h000_0004,
		S_NEG_LOAD = 26'h000_0008,
		S_STORE = 26'h000_0010,
		S_AND = 26'h000_0020,
		S_SUM = 26'h000_0040,
		S_INDEX_A = 26'h000_0080,
		S_INDEX_B = 26'h000_0100,
		S_CMP_A = 26'h000_0200,
		S_CMP_B = 26'h000_0400,
		S_DIFF = 26'h000_0800,
		S_PROD_FIRST = 26'h000_1000,
		S_PROD_REPEAT = 26'h000_2000,
		S_PROD_LAST = 26'h000_4000,
		S_QUOT_A = 26'h000_8000,
		S_QUOT_B = 26'h001_0000,
		S_NEXT_FETCH = 26'h002_0000,
		S_CNT_UP = 26'h004_0000,
		S_CNT_DOWN = 26'h008_0000,
		S_CNT_SHIFT = 26'h010_0000,
		S_CNT_SHIFT_P1 = 26'h020_0000,
		S_KICKOFF = 26'h040_0000,
		S_START_AT = 26'h080_0000,
		S_DISPLAY = 26'h100_0000,
		S_LOAD = 26'h200_0000
	} ocsd_step_t;

	// Counter cycle appended after an add or subtract
	typedef enum logic [2:0] {
		P_NONE = 3'h1,
		P_UP = 3'h2,
		P_DOWN = 3'h4
	} ocsd_pend_t;

endpackage

// ===== core/ocsd_action_timer.sv
// Action timer: numbers the twelve actions of each memory cycle
`timescale 1ns/1ps
`include "ocsd_map.svh"
module ocsd_action_timer #(
	parameter int ACTIONS = `OCSD_ACT_COUNT
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic run,
	output logic [3:0] action,
	output logic mct_end
);
	logic [3:0] action_q;
	logic [3:0] action_d;

	// Last action of the memory cycle
	assign mct_end = run && (action_q == 4'(ACTIONS));
	assign action = action_q;

	// Step through actions, rest at the first while stopped
	always_comb begin
		action_d = action_q;
		if (!run || mct_end) begin
			action_d = `OCSD_ACT_FIRST;
		end else begin
			action_d = action_q + 4'h1;
		end
	end

	// Register the action number
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			action_q <= `OCSD_ACT_FIRST;
		end else begin
			action_q <= action_d;
		end
	end
endmodule

// ===== core/ocsd_decode.sv
// Order code decode: first subinstruction, its length, undefined codes
`timescale 1ns/1ps
`include "ocsd_map.svh"
module ocsd_decode #(
	parameter int EXTRA_OVH = `OCSD_EXTRA_OVH
) (
	input wire logic [3:0] order_code,
	input wire logic extra_code,
	output ocsd_pkg::ocsd_step_t first_step,
	output logic [4:0] first_rep,
	output logic undefined
);
	// Map a regular or extra code onto its opening subinstruction
	always_comb begin
		first_step = ocsd_pkg::S_IDLE;
		first_rep = `OCSD_REP_ONE;
		undefined = 1'b0;
		if (!extra_code) begin
			case (order_code)
				`OCSD_OC_BRANCH: first_step = ocsd_pkg::S_BRANCH;
				`OCSD_OC_SWAP: first_step = ocsd_pkg::S_SWAP;
				`OCSD_OC_NEG_LOAD: first_step = ocsd_pkg::S_NEG_LOAD;
				`OCSD_OC_STORE: first_step = ocsd_pkg::S_STORE;
				`OCSD_OC_AND: first_step = ocsd_pkg::S_AND;
				`OCSD_OC_SUM: first_step = ocsd_pkg::S_SUM;
				`OCSD_OC_INDEX: first_step = ocsd_pkg::S_INDEX_A;
				`OCSD_OC_COMPARE_SKIP: first_step = ocsd_pkg::S_CMP_A;
				default: undefined = 1'b1;
			endcase
		end else begin
			// Extra codes spend the overhead cycles in their first step
			first_rep = 5'(1 + EXTRA_OVH);
			case (order_code)
				`OCSD_XC_DIFFERENCE: first_step = ocsd_pkg::S_DIFF;
				`OCSD_XC_PRODUCT: first_step = ocsd_pkg::S_PROD_FIRST;
				`OCSD_XC_QUOTIENT: first_step = ocsd_pkg::S_QUOT_A;
				default: begin
					undefined = 1'b1;
					first_rep = `OCSD_REP_ONE;
				end
			endcase
		end
	end
endmodule

// ===== tb/ocsd_monitor.sv
// Port checker for the order code sequence decoder
`timescale 1ns/1ps
module ocsd_monitor #(
	parameter int PROD_REPEAT = 6,
	parameter int QUOT_REPEAT = 14,
	parameter int EXTRA_OVH = 2
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic order_valid,
	input wire logic [3:0] order_code,
	input wire logic extra_code,
	input wire logic order_ready,
	input wire logic [7:0] inv_req,
	input wire logic [7:0] inv_ack,
	input wire logic sum_overflow,
	input wire logic sum_underflow,
	input wire ocsd_pkg::ocsd_step_t step,
	input wire logic [3:0] action,
	input wire logic action_end,
	input wire logic [4:0] mct_index,
	input wire logic seq_done,
	input wire logic undefined_code
);
	logic take;
	logic busy;
	// Handshake and busy decodes
	assign take = order_valid && order_ready;
	assign busy = step != ocsd_pkg::S_IDLE;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_ACT_RANGE: assert property (action >= 4'h1 && action <= 4'hC)
		else $error("action number out of range");
	AST_ACT_END: assert property (action_end == (busy && action == 4'hC))
		else $error("action end misplaced");
	AST_ACT_STEP: assert property (busy && !action_end |=>
		action == $past(action) + 4'h1 && $stable(step))
		else $error("action count or step moved inside a cycle");
	AST_BRANCH: assert property (take && !extra_code && order_code == 4'h0 |=>
		step == ocsd_pkg::S_BRANCH && seq_done && mct_index == 5'h01)
		else $error("branch not a single final cycle");
	AST_SWAP: assert property (take && !extra_code && order_code == 4'h3 |=>
		step == ocsd_pkg::S_SWAP ##12 step == ocsd_pkg::S_NEXT_FETCH && seq_done)
		else $error("swap sequence wrong");
	AST_PROD: assert property (take && extra_code && order_code == 4'h9 |=>
		step == ocsd_pkg::S_PROD_FIRST ##36 step == ocsd_pkg::S_PROD_REPEAT
		##72 step == ocsd_pkg::S_PROD_LAST && seq_done)
		else $error("product sequence wrong");
	AST_UNDEF: assert property (take && !extra_code && order_code inside {[4'h4:4'hB]}
		|=> undefined_code && !busy)
		else $error("undefined code not flagged");
	AST_INV: assert property (inv_ack != 8'h00 |->
		$onehot(inv_ack) && (inv_ack & inv_req) == inv_ack ##1 busy && seq_done)
		else $error("involuntary grant wrong");
	AST_REFUSE: assert property (busy && !(seq_done && action_end) |->
		!order_ready && inv_ack == 8'h00)
		else $error("request taken off boundary");
endmodule

// ===== tb/ocsd_inv_partner.sv
// Requester model for involuntary counter, start, display and load requests
`timescale 1ns/1ps
module ocsd_inv_partner (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic go,
	input wire logic [2:0] idx,
	input wire logic [7:0] inv_ack,
	output logic [7:0] inv_req
);
	// Raise a request, hold it until its grant is seen at an edge
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			inv_req <= 8'h00;
		end else begin
			inv_req <= (inv_req & ~inv_ack) | (go ? 8'h01 << idx : 8'h00);
		end
	end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the order code sequence decoder
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, reset, order_valid, extra_code, order_ready;
	logic [3:0] order_code;
	logic [7:0] inv_req, inv_ack;
	logic sum_overflow, sum_underflow, action_end, seq_done, undefined_code, go;
	ocsd_pkg::ocsd_step_t step;
	logic [3:0] action;
	logic [4:0] mct_index;
	logic [2:0] idx;
	int mismatches, comparisons, seed;
	ocsd_pkg::ocsd_step_t exp_q[$];
	int codes[11] = '{0, 1, 2, 3, 12, 13, 14, 15, 9, 10, 11};
	ocsd_pkg::ocsd_step_t inv_steps[8] = '{ocsd_pkg::S_KICKOFF, ocsd_pkg::S_START_AT,
		ocsd_pkg::S_CNT_UP, ocsd_pkg::S_CNT_DOWN, ocsd_pkg::S_CNT_SHIFT,
		ocsd_pkg::S_CNT_SHIFT_P1, ocsd_pkg::S_DISPLAY, ocsd_pkg::S_LOAD};
	ocsd_sequencer ocsd_sequencer_inst (.ref_clk, .reset, .order_valid, .order_code,
		.extra_code, .order_ready, .inv_req, .inv_ack, .sum_overflow, .sum_underflow,
		.step, .action, .action_end, .mct_index, .seq_done, .undefined_code);
	ocsd_inv_partner ocsd_inv_partner_inst (.ref_clk, .reset, .go, .idx, .inv_ack, .inv_req);
	// Clock, 5 ns period
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input bit ok, input string msg);
		comparisons++;
		if (!ok) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	// Reference sequence of subinstructions for one instruction
	task automatic model(input int c, input bit x, input int ou);
		exp_q.delete();
		if (x) begin
			case (c)
				9: begin
					repeat (3) exp_q.push_back(ocsd_pkg::S_PROD_FIRST);
					repeat (6) exp_q.push_back(ocsd_pkg::S_PROD_REPEAT);
					exp_q.push_back(ocsd_pkg::S_PROD_LAST);
				end
				10: begin
					repeat (3) exp_q.push_back(ocsd_pkg::S_QUOT_A);
					repeat (14) exp_q.push_back(ocsd_pkg::S_QUOT_B);
				end
				default: repeat (3) exp_q.push_back(ocsd_pkg::S_DIFF);
			endcase
		end else begin
			case (c)
				0: exp_q.push_back(ocsd_pkg::S_BRANCH);
				1: exp_q = '{ocsd_pkg::S_CMP_A, ocsd_pkg::S_CMP_B};
				2: exp_q = '{ocsd_pkg::S_INDEX_A, ocsd_pkg::S_INDEX_B};
				3: exp_q.push_back(ocsd_pkg::S_SWAP);
				12: exp_q.push_back(ocsd_pkg::S_NEG_LOAD);
				13: exp_q.push_back(ocsd_pkg::S_STORE);
				14: exp_q.push_back(ocsd_pkg::S_SUM);
				default: exp_q.push_back(ocsd_pkg::S_AND);
			endcase
		end
		if (c > 2 && !(x && c == 9)) exp_q.push_back(ocsd_pkg::S_NEXT_FETCH);
		if ((c == 14 && !x) || (c == 11 && x)) begin
			if (ou == 1) exp_q.push_back(ocsd_pkg::S_CNT_UP);
			if (ou == 2) exp_q.push_back(ocsd_pkg::S_CNT_DOWN);
		end
	endtask
	// Offer an order code until taken, then drop it
	task automatic issue(input int c, input bit x);
		int n;
		order_code = 4'(c);
		extra_code = x;
		order_valid = 1'b1;
		for (n = 0; n < 400 && order_ready !== 1'b1; n++) @(negedge ref_clk);
		check(n < 400, "order never taken");
		if (n == 400) final_report();
		@(negedge ref_clk);
		order_valid = 1'b0;
	endtask
	// Record the step of each memory cycle until the final action
	task automatic collect(input string name);
		ocsd_pkg::ocsd_step_t got[$];
		int n;
		for (n = 0; n < 400; n++) begin
			if (step !== ocsd_pkg::S_IDLE && action === 4'h1) begin
				check(mct_index === 5'(got.size() + 1), "cycle index");
				got.push_back(step);
			end
			if (seq_done === 1'b1 && action_end === 1'b1) break;
			@(negedge ref_clk);
		end
		check(n < 400, "no final cycle");
		if (n == 400) final_report();
		check(got.size() == exp_q.size(), "cycle count");
		for (n = 0; n < got.size() && n < exp_q.size(); n++) begin
			check(got[n] === exp_q[n], "step order");
		end
		$display("test %s done", name);
	endtask
	// Main sequence
	initial begin
		int r;
		int i;
		bit un;
		seed = 30418;
		reset = 1'b1;
		order_valid = 1'b0;
		order_code = 4'h0;
		extra_code = 1'b0;
		sum_overflow = 1'b0;
		sum_underflow = 1'b0;
		go = 1'b0;
		idx = 3'h0;
		repeat (3) @(negedge ref_clk);
		reset = 1'b0;
		for (r = 0; r < 3; r++) begin
			for (i = 0; i < 11; i++) begin
				un = (r == 2) || (($random(seed) & 1) != 0);
				sum_overflow = (r == 1);
				sum_underflow = un;
				model(codes[i], i > 7, (r == 1) ? 1 : (un ? 2 : 0));
				issue(codes[i], i > 7);
				collect("order code");
			end
		end
		issue(4, 1'b0);
		check(undefined_code === 1'b1 && step === ocsd_pkg::S_IDLE, "undefined");
		$display("test undefined done");
		for (i = 0; i < 8; i++) begin
			exp_q = '{inv_steps[i]};
			idx = 3'(i);
			go = 1'b1;
			@(negedge ref_clk);
			go = 1'b0;
			collect("involuntary");
		end
		final_report();
	end
endmodule
bind ocsd_sequencer ocsd_monitor #(.PROD_REPEAT(PROD_REPEAT), .QUOT_REPEAT(QUOT_REPEAT),
	.EXTRA_OVH(EXTRA_OVH)) ocsd_monitor_inst (.ref_clk, .reset, .order_valid, .order_code,
	.extra_code, .order_ready, .inv_req, .inv_ack, .sum_overflow, .sum_underflow,
	.step, .action, .action_end, .mct_index, .seq_done, .undefined_code);
